// *** core_fault_pkg.sv ***
// Constants and types shared by the fault exception entry unit
package core_fault_pkg;
	// ----------------------------------------
	// Vector offsets from the selected base
	// ----------------------------------------
	localparam logic [31:0] OFS_EMUL = 32'h0000_1000;
	localparam logic [31:0] OFS_ITLB_MISS = 32'h0000_1100;
	localparam logic [31:0] OFS_DTLB_MISS = 32'h0000_1200;
	localparam logic [31:0] OFS_ITLB_ERR = 32'h0000_1300;
	localparam logic [31:0] OFS_DTLB_ERR = 32'h0000_1400;
	localparam logic [31:0] OFS_BRK_DATA = 32'h0000_1c00;
	localparam logic [31:0] OFS_BRK_INSTR = 32'h0000_1d00;
	localparam logic [31:0] OFS_BRK_MASK = 32'h0000_1e00;
	localparam logic [31:0] OFS_PORT_NMI = 32'h0000_1f00;
	// ----------------------------------------
	// Machine state bits, bit 0 is the LSB here
	// ----------------------------------------
	localparam int unsigned MS_ILE = 15;
	localparam int unsigned MS_ME = 12;
	localparam int unsigned MS_IP = 6;
	localparam int unsigned MS_IR = 5;
	localparam int unsigned MS_DR = 4;
	localparam int unsigned MS_RI = 1;
	localparam int unsigned MS_LE = 0;
	// Bits that survive an entry
	localparam logic [31:0] MS_KEEP = (32'h1 << MS_IP) | (32'h1 << MS_ME);
	// Low half of machine state copied into save-restore status
	localparam int unsigned MS_COPY_W = 16;
	// ----------------------------------------
	// Save-restore status flags (MSB-first bit n sits at 31-n)
	// ----------------------------------------
	localparam int unsigned SRS_ABSENT = 30;
	localparam int unsigned SRS_GUARD = 28;
	localparam int unsigned SRS_PROT = 27;
	localparam int unsigned SRS_MISS = 21;
	// ----------------------------------------
	// Data fault status flags
	// ----------------------------------------
	localparam int unsigned DFS_ABSENT = 30;
	localparam int unsigned DFS_PROT = 27;
	localparam int unsigned DFS_STORE = 25;
	// ----------------------------------------
	// Register word indices and reset values
	// ----------------------------------------
	localparam logic [2:0] REG_SRP = 3'h0;
	localparam logic [2:0] REG_SRS = 3'h1;
	localparam logic [2:0] REG_MS = 3'h2;
	localparam logic [2:0] REG_DFS = 3'h3;
	localparam logic [2:0] REG_DFA = 3'h4;
	localparam logic [2:0] REG_BKA = 3'h5;
	localparam logic [2:0] REG_CTRL = 3'h6;
	localparam int unsigned NUM_REGS = 6;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] MS_RESET = 32'h0000_0000;
	// Control word fields
	localparam int unsigned CTL_REV1 = 0;
	localparam int unsigned CTL_UNDEF = 1;
	localparam int unsigned CTL_CAUSE = 4;
	localparam logic CTL_REV1_RESET = 1'b1;
	// ----------------------------------------
	// Entry causes
	// ----------------------------------------
	typedef enum logic [3:0] {
		CAUSE_NONE = 4'h0,
		CAUSE_EMUL = 4'h1,
		CAUSE_ITLB_MISS = 4'h2,
		CAUSE_ITLB_ERR = 4'h3,
		CAUSE_DTLB_MISS = 4'h4,
		CAUSE_DTLB_ERR = 4'h5,
		CAUSE_BRK_INSTR = 4'h6,
		CAUSE_BRK_DATA = 4'h7,
		CAUSE_BRK_MASK = 4'h8,
		CAUSE_PORT_NMI = 4'h9
	} cause_e;
	// Fault requests from fetch, load/store, translation and debug logic
	typedef struct packed {
		logic emul_unimpl;
		logic fetch_miss;
		logic fetch_absent;
		logic fetch_prot;
		logic fetch_guard;
		logic data_miss;
		logic data_absent;
		logic data_prot;
		logic data_nochange;
		logic data_store;
		logic data_multi;
		logic data_nonfirst;
		logic align;
		logic brk_instr;
		logic brk_data;
		logic brk_periph;
		logic port_mask;
		logic port_nmi;
	} fault_req_s;
	// Addresses that go with a request
	typedef struct packed {
		logic [31:0] instr_addr;
		logic [31:0] next_addr;
		logic [31:0] data_addr;
	} fault_addr_s;
endpackage : core_fault_pkg

// *** core_fault_exception_entry.sv ***
// Exception entry unit: cause selection, save registers, vectors, bus slave
// Summary of operation
// - Emulation entry saves pc, vectors 0x1000
// - Status low half copied from machine state
// - Entry keeps base and check bits, copies ILE into LE
// - Fetch miss with translation sets bits 4,10
// - Fetch miss vectors to 0x1100
// - Fetch error on absent, protection or guarded
// - Fetch error flags absent, guard, protection
// - First revision adds bits 3,10 on protection
// - Fetch error saves pc, vectors 0x1300
// - Data miss with translation clears status flags
// - Data miss vectors to 0x1200
// - Data error on absent, protection, unchanged write
// - Data error loads fault status and address
// - Data error vectors to 0x1400
// - Debug entry on breakpoint or port request
// - Debug saved pc depends on breakpoint kind
// - Port request at reset leaves saves undefined
// - Data breakpoint loads breakpoint address only
// - Debug vectors 0x1d00, 0x1c00, 0x1e00, 0x1f00
// - Later access miss allows partial, base kept
// - Alignment condition suppresses all results
// - Unimplemented optional facility takes emulation
`timescale 1ns/10ps
module core_fault_exception_entry #(
	parameter logic [31:0] HIGH_BASE = 32'hfff0_0000,
	parameter logic [31:0] LOW_BASE = 32'h0000_0000
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Fault sources
	input wire core_fault_pkg::fault_req_s req_in,
	input wire core_fault_pkg::fault_addr_s addr_in,
	// Entry results
	output logic entry_out,
	output logic [31:0] vector_out,
	output logic [3:0] cause_out,
	output logic suppress_out,
	output logic partial_out,
	output logic keep_base_out,
	output logic [31:0] machine_state_out
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Byte-lane merge of a bus write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction : be_merge

	// Vector offset of each cause
	function automatic logic [31:0] vec_offset(input core_fault_pkg::cause_e c);
		case (c)
			core_fault_pkg::CAUSE_EMUL: return core_fault_pkg::OFS_EMUL;
			core_fault_pkg::CAUSE_ITLB_MISS: return core_fault_pkg::OFS_ITLB_MISS;
			core_fault_pkg::CAUSE_DTLB_MISS: return core_fault_pkg::OFS_DTLB_MISS;
			core_fault_pkg::CAUSE_ITLB_ERR: return core_fault_pkg::OFS_ITLB_ERR;
			core_fault_pkg::CAUSE_DTLB_ERR: return core_fault_pkg::OFS_DTLB_ERR;
			core_fault_pkg::CAUSE_BRK_INSTR: return core_fault_pkg::OFS_BRK_INSTR;
			core_fault_pkg::CAUSE_BRK_DATA: return core_fault_pkg::OFS_BRK_DATA;
			core_fault_pkg::CAUSE_BRK_MASK: return core_fault_pkg::OFS_BRK_MASK;
			core_fault_pkg::CAUSE_PORT_NMI: return core_fault_pkg::OFS_PORT_NMI;
			default: return 32'h0000_0000;
		endcase
	endfunction : vec_offset

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0] reg_q [core_fault_pkg::NUM_REGS]; // Software-visible registers
	logic entry_q; // Entry pulse
	logic [31:0] vector_q; // Fetch address of handler
	core_fault_pkg::cause_e cause_q; // Last cause taken
	logic suppress_q; // Discard all results of the instruction
	logic partial_q; // Earlier accesses of the instruction stand
	logic keep_base_q; // Update-form base register not written
	logic [31:0] readdata_q; // Bus read data
	logic wait_q; // Bus wait request
	logic rev1_q; // First-revision flag behaviour
	logic undef_q; // Save registers not trustworthy

	// ----------------------------------------
	// Qualified fault conditions
	// ----------------------------------------
	logic [31:0] ms; // Current machine state
	logic itlb_miss_v; // Fetch miss under translation
	logic guard_v; // Guarded fetch under translation
	logic itlb_err_v; // Fetch error
	logic dtlb_miss_v; // Data miss under translation
	logic dtlb_err_v; // Data error
	logic dbg_mask_v; // Maskable port or peripheral breakpoint
	assign ms = reg_q[core_fault_pkg::REG_MS];
	assign itlb_miss_v = req_in.fetch_miss & ms[core_fault_pkg::MS_IR];
	assign guard_v = req_in.fetch_guard & ms[core_fault_pkg::MS_IR];
	assign itlb_err_v = req_in.fetch_absent | req_in.fetch_prot | guard_v;
	assign dtlb_miss_v = req_in.data_miss & ms[core_fault_pkg::MS_DR];
	// Unchanged-page fault only matters for a write
	assign dtlb_err_v = req_in.data_absent | req_in.data_prot |
		(req_in.data_nochange & req_in.data_store);
	assign dbg_mask_v = req_in.brk_periph | req_in.port_mask;

	// ----------------------------------------
	// Cause priority
	// ----------------------------------------
	// Non-maskable port request first, then fetch-side causes; an alignment condition blocks the data-side and maskable debug ones
	core_fault_pkg::cause_e sel_cause;
	logic take;
	assign sel_cause = req_in.port_nmi ? core_fault_pkg::CAUSE_PORT_NMI :
		itlb_miss_v ? core_fault_pkg::CAUSE_ITLB_MISS :
		itlb_err_v ? core_fault_pkg::CAUSE_ITLB_ERR :
		req_in.brk_instr ? core_fault_pkg::CAUSE_BRK_INSTR :
		req_in.emul_unimpl ? core_fault_pkg::CAUSE_EMUL :
		req_in.align ? core_fault_pkg::CAUSE_NONE :
		dtlb_miss_v ? core_fault_pkg::CAUSE_DTLB_MISS :
		dtlb_err_v ? core_fault_pkg::CAUSE_DTLB_ERR :
		req_in.brk_data ? core_fault_pkg::CAUSE_BRK_DATA :
		dbg_mask_v ? core_fault_pkg::CAUSE_BRK_MASK :
		core_fault_pkg::CAUSE_NONE;
	assign take = sel_cause != core_fault_pkg::CAUSE_NONE;

	// ----------------------------------------
	// Values loaded on entry
	// ----------------------------------------
	logic is_itlb_err; // Fetch error selected
	logic is_itlb_miss; // Fetch miss selected
	logic ie_prot; // Fetch protection violation selected
	logic [31:0] base_sel; // Base picked by vector-base bit
	logic [31:0] vector_d; // Handler address
	logic [31:0] pc_save; // Saved program counter
	logic [31:0] data_addr; // Data access address
	logic [31:0] srs_flags; // Cause flags of save-restore status
	logic [31:0] srs_val; // Save-restore status image
	logic [31:0] ms_entry; // Machine state after entry
	logic [31:0] dfs_val; // Data fault status image
	logic partial_d; // Partial completion allowed
	assign is_itlb_err = sel_cause == core_fault_pkg::CAUSE_ITLB_ERR;
	assign is_itlb_miss = sel_cause == core_fault_pkg::CAUSE_ITLB_MISS;
	assign ie_prot = is_itlb_err & req_in.fetch_prot;
	assign base_sel = ms[core_fault_pkg::MS_IP] ? HIGH_BASE : LOW_BASE;
	assign vector_d = base_sel | vec_offset(sel_cause);
	assign data_addr = addr_in.data_addr;
	// Data and maskable debug entries resume after the current instruction
	assign pc_save = (sel_cause == core_fault_pkg::CAUSE_BRK_DATA ||
		sel_cause == core_fault_pkg::CAUSE_BRK_MASK) ? addr_in.next_addr :
		addr_in.instr_addr;
	// Only fetch causes set flags; all others leave bits 1-4 and 10-15 clear
	assign srs_flags = (32'(is_itlb_err & req_in.fetch_absent) << core_fault_pkg::SRS_ABSENT) |
		(32'(is_itlb_err & (guard_v | (req_in.fetch_prot & rev1_q)))
		<< core_fault_pkg::SRS_GUARD) |
		(32'(ie_prot | is_itlb_miss) << core_fault_pkg::SRS_PROT) |
		(32'((ie_prot & rev1_q) | is_itlb_miss) << core_fault_pkg::SRS_MISS);
	assign srs_val = srs_flags |
		{16'h0000, ms[core_fault_pkg::MS_COPY_W-1:0]};
	assign ms_entry = (ms & core_fault_pkg::MS_KEEP) |
		(32'(ms[core_fault_pkg::MS_ILE]) << core_fault_pkg::MS_LE);
	assign dfs_val = (32'(req_in.data_absent) << core_fault_pkg::DFS_ABSENT) |
		(32'(req_in.data_prot) << core_fault_pkg::DFS_PROT) |
		(32'(req_in.data_store) << core_fault_pkg::DFS_STORE);
	assign partial_d = (sel_cause == core_fault_pkg::CAUSE_DTLB_MISS) &
		req_in.data_multi & req_in.data_nonfirst;

	// ----------------------------------------
	// Hardware loads of the register file
	// ----------------------------------------
	logic [core_fault_pkg::NUM_REGS-1:0] hw_we; // Hardware write per register
	logic [31:0] hw_val [core_fault_pkg::NUM_REGS]; // Hardware value per register
	logic is_dtlb_err; // Data error selected
	logic is_brk_data; // Data breakpoint selected
	assign is_dtlb_err = sel_cause == core_fault_pkg::CAUSE_DTLB_ERR;
	assign is_brk_data = sel_cause == core_fault_pkg::CAUSE_BRK_DATA;
	// Data breakpoint touches neither fault status nor fault address
	assign hw_we = {is_brk_data, is_dtlb_err, is_dtlb_err, take, take, take};
	assign hw_val[core_fault_pkg::REG_SRP] = pc_save;
	assign hw_val[core_fault_pkg::REG_SRS] = srs_val;
	assign hw_val[core_fault_pkg::REG_MS] = ms_entry;
	assign hw_val[core_fault_pkg::REG_DFS] = dfs_val;
	assign hw_val[core_fault_pkg::REG_DFA] = data_addr;
	assign hw_val[core_fault_pkg::REG_BKA] = data_addr;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [2:0] word; // Word index of access
	logic bus_req; // Request present
	logic bus_done; // Request completes at this edge
	logic bus_wr; // Write completes at this edge
	logic [31:0] ctrl_view; // Control word read image
	logic [31:0] rd_word; // Read mux
	assign word = avs_address_in[4:2];
	assign bus_req = avs_read_in | avs_write_in;
	assign bus_done = bus_req & ~wait_q;
	assign bus_wr = bus_done & avs_write_in;
	assign ctrl_view = (32'(rev1_q) << core_fault_pkg::CTL_REV1) |
		(32'(undef_q) << core_fault_pkg::CTL_UNDEF) |
		(32'(cause_q) << core_fault_pkg::CTL_CAUSE);
	// Unmapped words read as zero
	assign rd_word = (word < 3'(core_fault_pkg::NUM_REGS)) ? reg_q[word] :
		(word == core_fault_pkg::REG_CTRL) ? ctrl_view : 32'h0000_0000;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// An entry in the same cycle as a software write wins
	for (genvar i = 0; i < core_fault_pkg::NUM_REGS; i++) begin : g_reg
		logic sw_we;
		logic [31:0] rst_val;
		assign sw_we = bus_wr & (word == 3'(i));
		assign rst_val = (i == core_fault_pkg::REG_MS) ? core_fault_pkg::MS_RESET :
			core_fault_pkg::REG_RESET;
		always_ff @(posedge clock_in) begin
			if (!nrst_in) begin
				reg_q[i] <= rst_val;
			end else if (hw_we[i]) begin
				reg_q[i] <= hw_val[i];
			end else if (sw_we) begin
				reg_q[i] <= be_merge(reg_q[i], avs_writedata_in, avs_byteenable_in);
			end
		end
	end

	// ----------------------------------------
	// Entry outputs
	// ----------------------------------------
	// Registered handler address and instruction fate
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			entry_q <= 1'b0;
			vector_q <= 32'h0000_0000;
			cause_q <= core_fault_pkg::CAUSE_NONE;
			suppress_q <= 1'b0;
			partial_q <= 1'b0;
			keep_base_q <= 1'b0;
		end else begin
			entry_q <= take;
			vector_q <= take ? vector_d : vector_q;
			cause_q <= take ? sel_cause : cause_q;
			suppress_q <= req_in.align | (take & ~partial_d);
			partial_q <= partial_d;
			keep_base_q <= take;
		end
	end

	// ----------------------------------------
	// Control and undefined-save flag
	// ----------------------------------------
	// A port request seen in reset marks the save registers untrusted
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			rev1_q <= core_fault_pkg::CTL_REV1_RESET; // Starts in first-revision form
			undef_q <= req_in.port_mask | req_in.port_nmi;
		end else begin
			if (bus_wr && word == core_fault_pkg::REG_CTRL && avs_byteenable_in[0]) begin
				rev1_q <= avs_writedata_in[core_fault_pkg::CTL_REV1];
			end
			if (take && sel_cause != core_fault_pkg::CAUSE_PORT_NMI &&
				sel_cause != core_fault_pkg::CAUSE_BRK_MASK) begin
				undef_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	// Wait drops for one cycle per request; data is ready when it drops
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			wait_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(bus_req & wait_q);
			if (avs_read_in && wait_q) begin
				readdata_q <= rd_word;
			end
		end
	end

	// ----------------------------------------
	// Output drive
	// ----------------------------------------
	assign avs_readdata_out = readdata_q;
	assign avs_waitrequest_out = wait_q;
	assign entry_out = entry_q;
	assign vector_out = vector_q;
	assign cause_out = cause_q;
	assign suppress_out = suppress_q;
	assign partial_out = partial_q;
	assign keep_base_out = keep_base_q;
	assign machine_state_out = reg_q[core_fault_pkg::REG_MS];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);

	property p_emul_vec;
		sel_cause == core_fault_pkg::CAUSE_EMUL |=> entry_out &&
			vector_out == ($past(base_sel) | core_fault_pkg::OFS_EMUL) &&
			reg_q[core_fault_pkg::REG_SRP] == $past(pc_save);
	endproperty
	a_emul_vec: assert property (p_emul_vec) else $error("emulation entry wrong");

	property p_srs_copy;
		entry_out |-> reg_q[core_fault_pkg::REG_SRS][15:0] == $past(ms[15:0]);
	endproperty
	a_srs_copy: assert property (p_srs_copy) else $error("status copy wrong");

	property p_ms_entry;
		take ##1 entry_out |-> ms[core_fault_pkg::MS_LE] == $past(ms[core_fault_pkg::MS_ILE]) &&
			ms[core_fault_pkg::MS_IP] == $past(ms[core_fault_pkg::MS_IP]) &&
			!ms[core_fault_pkg::MS_IR] && !ms[core_fault_pkg::MS_DR];
	endproperty
	a_ms_entry: assert property (p_ms_entry) else $error("machine state entry wrong");

	property p_itlb_miss;
		req_in.fetch_miss && ms[core_fault_pkg::MS_IR] && !req_in.port_nmi |=>
			cause_out == core_fault_pkg::CAUSE_ITLB_MISS &&
			reg_q[core_fault_pkg::REG_SRS][core_fault_pkg::SRS_PROT] &&
			reg_q[core_fault_pkg::REG_SRS][core_fault_pkg::SRS_MISS] &&
			vector_out == ($past(base_sel) | core_fault_pkg::OFS_ITLB_MISS);
	endproperty
	a_itlb_miss: assert property (p_itlb_miss) else $error("fetch miss entry wrong");

	property p_itlb_err;
		entry_out && cause_out == core_fault_pkg::CAUSE_ITLB_ERR && rev1_q |->
			reg_q[core_fault_pkg::REG_SRS][core_fault_pkg::SRS_MISS] ==
			reg_q[core_fault_pkg::REG_SRS][core_fault_pkg::SRS_PROT];
	endproperty
	a_itlb_err: assert property (p_itlb_err) else $error("fetch error flags wrong");

	property p_rev1;
		is_itlb_err && req_in.fetch_prot && rev1_q |=>
			reg_q[core_fault_pkg::REG_SRS][core_fault_pkg::SRS_GUARD];
	endproperty
	a_rev1: assert property (p_rev1) else $error("first revision guard flag missing");

	// Only the absent, protection and store flags may be set
	property p_dfs;
		is_dtlb_err |=> reg_q[core_fault_pkg::REG_DFA] == $past(data_addr) &&
			(reg_q[core_fault_pkg::REG_DFS] & 32'hb5ff_ffff) == 32'h0000_0000;
	endproperty
	a_dfs: assert property (p_dfs) else $error("data fault registers wrong");

	// Data breakpoint must leave both fault registers alone
	property p_bar_keep;
		is_brk_data && !bus_wr |=> $stable(reg_q[core_fault_pkg::REG_DFS]) &&
			$stable(reg_q[core_fault_pkg::REG_DFA]) &&
			reg_q[core_fault_pkg::REG_BKA] == $past(data_addr);
	endproperty
	a_bar_keep: assert property (p_bar_keep) else $error("breakpoint address wrong");

	property p_nmi_vec;
		req_in.port_nmi |=> cause_out == core_fault_pkg::CAUSE_PORT_NMI &&
			vector_out == ($past(base_sel) | core_fault_pkg::OFS_PORT_NMI);
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("port vector wrong");

	property p_partial;
		partial_d |=> partial_out && keep_base_out && !suppress_out;
	endproperty
	a_partial: assert property (p_partial) else $error("partial completion wrong");

	property p_align;
		req_in.align |=> suppress_out;
	endproperty
	a_align: assert property (p_align) else $error("alignment not suppressed");

	property p_bus;
		bus_req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer late");

	c_emul: cover property (sel_cause == core_fault_pkg::CAUSE_EMUL ##1 entry_out);
	c_itlb_prot: cover property (ie_prot ##1 entry_out);
	c_partial: cover property (partial_d ##1 partial_out);
	c_bus_rd: cover property (avs_read_in && !avs_waitrequest_out);
endmodule : core_fault_exception_entry

// *** fault_source_model.sv ***
// Model of the fetch, load/store, translation and breakpoint sources
`timescale 1ns/10ps
module fault_source_model (
	// Clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// Event asked for by the bench
	input wire logic fire_in,
	input wire core_fault_pkg::fault_req_s pat_in,
	input wire core_fault_pkg::fault_addr_s adr_in,
	// Toward the entry unit
	output core_fault_pkg::fault_req_s req_out,
	output core_fault_pkg::fault_addr_s addr_out
);
	// One cycle per event; released addresses flip every cycle, so stale values match on alternate cycles
	always_ff @(posedge clock_in) begin
		req_out <= (fire_in && nrst_in) ? pat_in : '0;
		addr_out <= !nrst_in ? '0 : (fire_in ? adr_in : ~addr_out);
	end
endmodule : fault_source_model

// *** core_fault_exception_entry_bench.sv ***
// Self-checking bench for the fault exception entry unit
`timescale 1ns/10ps
`define P core_fault_pkg::
`define CK(a,e) begin checks_done++; if ((a)!==(e)) begin bad_count++; \
	$display("[ERR] %0t mismatch got %h exp %h", $time, a, e); end end
module core_fault_exception_entry_bench;
	localparam logic [31:0] HB = 32'hffe0_0000; // High base under test
	logic clock_in = 1'b0, nrst_in = 1'b0, rd = 1'b0, wr = 1'b0, fire = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h0, rdat, vo, mso, ms, q, o, f;
	logic wt, ent, sup, par, kb, sel;
	logic [3:0] co, c;
	logic [2:0] r;
	logic [31:0] ex [6] = '{default: 32'h0}; // Expected register words
	`P fault_req_s pat = '0, rq, p;
	`P fault_addr_s ad = '0, aq, av;
	int bad_count = 0, checks_done = 0, k, i, rv;
	core_fault_exception_entry #(.HIGH_BASE(HB), .LOW_BASE(32'h0)) core_fault_exception_entry_i (
		.clock_in(clock_in), .nrst_in(nrst_in), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wt), .req_in(rq), .addr_in(aq),
		.entry_out(ent), .vector_out(vo), .cause_out(co), .suppress_out(sup),
		.partial_out(par), .keep_base_out(kb), .machine_state_out(mso));
	fault_source_model fault_source_model_i (.clock_in(clock_in), .nrst_in(nrst_in),
		.fire_in(fire), .pat_in(pat), .adr_in(ad), .req_out(rq), .addr_out(aq));
	// Clock and watchdog
	initial forever #2 clock_in = ~clock_in;
	initial begin
		repeat (100000) @(posedge clock_in);
		bad_count++;
		summarize();
	end
	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		rd <= !w;
		wr <= w;
		adr <= {a, 2'b00};
		wd <= d;
		// Wait and read data are the values that stood up to this rising edge
		do begin @(posedge clock_in); n++; end while (wt !== 1'b0 && n < 50);
		if (n >= 50) begin bad_count++; summarize(); end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	// Present one event through the source model, look after the entry edge
	task automatic fire_ev(input `P fault_req_s e);
		@(posedge clock_in);
		fire <= 1'b1;
		pat <= e;
		ad <= av;
		@(posedge clock_in);
		fire <= 1'b0;
		@(posedge clock_in);
		@(negedge clock_in);
	endtask : fire_ev
	// Read back all six state words
	task automatic chk_regs();
		for (int j = 0; j < 6; j++) begin
			bus(1'b0, 3'(j), 32'h0);
			`CK(q, ex[j])
		end
	endtask : chk_regs
	// Main sequence
	initial begin
		void'($urandom(56714));
		repeat (20) @(posedge clock_in);
		nrst_in <= 1'b1;
		chk_regs();
		bus(1'b0, `P REG_CTRL, 32'h0);
		`CK(q, 32'h1)
		for (rv = 1; rv >= 0; rv--) begin
			bus(1'b1, `P REG_CTRL, 32'(rv));
			for (k = 0; k < 36; k++) begin
				ms = $urandom | 32'h30;
				bus(1'b1, `P REG_MS, ms);
				p = '0; f = 32'h0; sel = 1'b0; r = 3'($urandom);
				av = {$urandom, $urandom, $urandom};
				case (k % 12)
					0: begin p.emul_unimpl = 1'b1; c = `P CAUSE_EMUL; o = `P OFS_EMUL; end
					1: begin p.fetch_miss = 1'b1; c = `P CAUSE_ITLB_MISS; f = 32'h0820_0000; end
					2: begin p.fetch_absent = 1'b1; f = 32'h4000_0000; end
					3: begin p.fetch_prot = 1'b1; f = rv ? 32'h1820_0000 : 32'h0800_0000; end
					4: begin p.fetch_guard = 1'b1; f = 32'h1000_0000; end
					5: begin p.data_miss = 1'b1; c = `P CAUSE_DTLB_MISS; o = `P OFS_DTLB_MISS; end
					6: begin // Data error with a random mix of absent, protection and store
						p.data_absent = r[0]; p.data_prot = r[1]; p.data_nochange = 1'b1;
						p.data_store = r[2] | !(r[0] | r[1]);
						c = `P CAUSE_DTLB_ERR; o = `P OFS_DTLB_ERR; ex[4] = av.data_addr;
						ex[3] = {1'b0, p.data_absent, 2'b00, p.data_prot, 1'b0, p.data_store, 25'h0};
					end
					7: begin p.brk_instr = 1'b1; c = `P CAUSE_BRK_INSTR; o = `P OFS_BRK_INSTR; end
					8: begin // Data breakpoint keeps fault registers
						p.brk_data = 1'b1; c = `P CAUSE_BRK_DATA; o = `P OFS_BRK_DATA;
						sel = 1'b1; ex[5] = av.data_addr;
					end
					9: begin p.brk_periph = 1'b1; sel = 1'b1; c = `P CAUSE_BRK_MASK; end
					10: begin p.port_mask = 1'b1; sel = 1'b1; c = `P CAUSE_BRK_MASK; end
					default: begin p.port_nmi = 1'b1; c = `P CAUSE_PORT_NMI; o = `P OFS_PORT_NMI; end
				endcase
				if (k % 12 == 1) o = `P OFS_ITLB_MISS;
				if (k % 12 >= 2 && k % 12 <= 4) begin c = `P CAUSE_ITLB_ERR; o = `P OFS_ITLB_ERR; end
				if (k % 12 == 9 || k % 12 == 10) o = `P OFS_BRK_MASK;
				fire_ev(p);
				`CK({ent, sup, kb}, 3'b111)
				`CK(vo, (ms[`P MS_IP] ? HB : 32'h0) | o)
				`CK(co, c)
				ex[0] = sel ? av.next_addr : av.instr_addr;
				ex[1] = f | {16'h0, ms[15:0]};
				ex[2] = (ms & `P MS_KEEP) | {31'h0, ms[`P MS_ILE]};
				`CK(mso, ex[2])
				chk_regs();
			end
		end
		// Misses without translation enabled are not taken
		bus(1'b1, `P REG_MS, 32'h0);
		p = '0; p.fetch_miss = 1'b1; p.data_miss = 1'b1;
		fire_ev(p);
		`CK(ent, 1'b0)
		// Alignment blocks the data miss and discards the results
		bus(1'b1, `P REG_MS, 32'h10);
		p = '0; p.align = 1'b1; p.data_miss = 1'b1;
		fire_ev(p);
		`CK({ent, sup}, 2'b01)
		// Later access of a multiple access misses: partial, base kept
		p.align = 1'b0; p.data_multi = 1'b1; p.data_nonfirst = 1'b1;
		fire_ev(p);
		`CK({ent, par, kb, sup, co}, {4'b1110, `P CAUSE_DTLB_MISS})
		// Unmapped word reads zero after a write
		bus(1'b1, 3'h7, $urandom);
		bus(1'b0, 3'h7, 32'h0);
		`CK(q, 32'h0)
		summarize();
	end
endmodule : core_fault_exception_entry_bench
